// ### design/eeprom_access_pkg.sv
/*
  Constants and carrier types for the data EEPROM access controller.
  Assumes an 8-bit I/O register port on the CPU clock, an EEPROM array
  with a combinational read port, and a calibrated RC oscillator
  output that arrives as a pin on another clock.
*/
package eeprom_access_pkg;

  // I/O register offsets
  localparam logic [5:0] OFS_ADDRESS_LOW  = 6'h21;
  localparam logic [5:0] OFS_ADDRESS_HIGH = 6'h22;
  localparam logic [5:0] OFS_DATA_BYTE    = 6'h23;
  localparam logic [5:0] OFS_CONTROL      = 6'h24;

  // address field layout
  localparam int ADDR_W      = 11;
  localparam int ADDR_HIGH_W = 3;

  // control register bit positions
  localparam int BIT_READY_INTERRUPT_ENABLE = 3;
  localparam int BIT_MASTER_WRITE_ENABLE    = 2;
  localparam int BIT_WRITE_STROBE           = 1;
  localparam int BIT_READ_STROBE            = 0;

  // reset values
  localparam logic [7:0] RESET_RDATA        = 8'h00;
  localparam logic [7:0] RESET_DATA_BYTE    = 8'h00;
  localparam logic [2:0] RESET_STALL        = 3'h0;
  localparam logic [2:0] RESET_MWE_COUNT    = 3'h0;
  localparam logic [14:0] RESET_RC_COUNT    = 15'h0000;

  // timing counts in CPU clock cycles
  localparam logic [2:0] MWE_WINDOW_CYCLES  = 3'h4;
  localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;
  localparam logic [2:0] READ_STALL_CYCLES  = 3'h4;

  // write duration in calibrated RC oscillator cycles (27,072)
  localparam logic [14:0] WRITE_RC_CYCLES   = 15'h69c0;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic              start;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } array_req_t;

endpackage

// ### design/eeprom_write_timer.sv
/*
  Self-timing for one EEPROM programming operation, counted in rising
  edges of the calibrated RC oscillator.
  Assumes por_rst is the power-on reset only, so a system reset does not
  cut a write short, and that rc_clk_pin is asynchronous to core_clk.
*/
`timescale 1ns/1ns
module eeprom_write_timer #(
  parameter logic [14:0] WRITE_RC_CYCLES = eeprom_access_pkg::WRITE_RC_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic por_rst,
  input  wire logic rc_clk_pin,
  input  wire logic start,
  output logic      busy
);

  logic        rc_sync1;
  logic        rc_sync2;
  logic        rc_prev;
  logic [14:0] rc_count;
  logic        rc_tick;

  always_ff @(posedge core_clk or posedge por_rst) begin
    if (por_rst) begin
      rc_sync1 <= 1'b0;
      rc_sync2 <= 1'b0;
      rc_prev  <= 1'b0;
    end else begin
      rc_sync1 <= rc_clk_pin;
      rc_sync2 <= rc_sync1;
      rc_prev  <= rc_sync2;
    end
  end

  assign rc_tick = rc_sync2 & ~rc_prev;

  // only power-on clears this, so a write in flight survives a reset
  always_ff @(posedge core_clk or posedge por_rst) begin // R19
    if (por_rst) begin
      busy     <= 1'b0;
      rc_count <= eeprom_access_pkg::RESET_RC_COUNT;
    end else if (start && !busy) begin
      busy     <= 1'b1;
      rc_count <= eeprom_access_pkg::RESET_RC_COUNT;
    end else if (busy && rc_tick) begin
      if (rc_count == WRITE_RC_CYCLES - 15'h0001) begin // R14
        busy <= 1'b0; // R9
      end else begin
        rc_count <= rc_count + 15'h0001;
      end
    end
  end

endmodule

// ### design/eeprom_access_controller.sv
/*
  CPU-side access controller for the on-chip data EEPROM: address, data
  and control registers on the I/O port, write window, write timing,
  CPU stalls and the ready interrupt request.
  Assumes the I/O port is synchronous to core_clk, the EEPROM array has
  a combinational read port and takes a start pulse to program a byte,
  and the interrupt controller ANDs nothing further onto ready_irq.
*/
// What this block and its software must do
// R1 - address bits 15 to 11 always read as zero
// R2 - eleven-bit address picks one byte linearly in the array
// R3 - address undefined after reset; software loads it before access
// R4 - write programs the data byte at address; read loads it
// R5 - control bits 7 to 4 always read as zero
// R6 - ready request held while enabled, interrupts on, strobe clear
// R7 - master write enable clears itself four clocks after being set
// R8 - write strobe starts a write only while master enable is set
// R9 - write strobe stays set until programming time has elapsed
// R10 - starting a write stalls the CPU for two cycles
// R11 - read strobe loads data at once and stalls CPU four cycles
// R12 - no read and no address change while a write runs
// R13 - no write starts while flash self-programming is active
// R14 - write lasts 27,072 calibrated RC oscillator cycles
// R15 - software sets master enable then strobe within four clocks
// R16 - software keeps interrupts off during the write sequence
// R17 - a write in power-down completes; its oscillator stays on
// R18 - software checks write done before entering power-down
// R19 - a write in progress finishes even through a reset
// R20 - writes to reserved address and control bits are ignored
`timescale 1ns/1ns
module eeprom_access_controller #(
  parameter logic [14:0] WRITE_RC_CYCLES = eeprom_access_pkg::WRITE_RC_CYCLES
) (
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  input  wire logic                          por_rst,
  input  wire eeprom_access_pkg::io_req_t    io_req,
  output logic [7:0]                         io_rdata,
  input  wire logic                          global_int_enable,
  input  wire logic                          flash_selfprog_enable,
  input  wire logic                          rc_clk_pin,
  input  wire logic [7:0]                    array_rdata,
  output logic [eeprom_access_pkg::ADDR_W-1:0] array_read_addr,
  output eeprom_access_pkg::array_req_t      array_req,
  output logic                               cpu_stall,
  output logic                               ready_irq,
  output logic                               rc_osc_keep_on
);

  logic [7:0]                                address_low;
  logic [eeprom_access_pkg::ADDR_HIGH_W-1:0] address_high;
  logic [7:0]                                eeprom_data_byte;
  logic                                      ready_interrupt_enable;
  logic                                      master_write_enable;
  logic [2:0]                                mwe_count;
  logic [2:0]                                stall_left;
  logic                                      write_busy;
  logic                                      ctrl_wr;
  logic                                      write_go;
  logic                                      read_go;
  logic [eeprom_access_pkg::ADDR_W-1:0]      eeprom_address;

  // one decode shared by the write strobes and the read mux
  function automatic logic hit(input logic [5:0] addr,
                               input logic [5:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic [7:0] control_view(input logic rie,
                                              input logic mwe,
                                              input logic busy);
    logic [7:0] v;
    v = 8'h00; // R5
    v[eeprom_access_pkg::BIT_READY_INTERRUPT_ENABLE] = rie;
    v[eeprom_access_pkg::BIT_MASTER_WRITE_ENABLE]    = mwe;
    v[eeprom_access_pkg::BIT_WRITE_STROBE]           = busy;
    control_view = v;
  endfunction

  assign eeprom_address = {address_high, address_low}; // R2

  assign ctrl_wr = io_req.wr && hit(io_req.addr,
                                    eeprom_access_pkg::OFS_CONTROL);

  // strobe is dropped unless the window is open, flash is idle and no write runs
  assign write_go = ctrl_wr
    && io_req.wdata[eeprom_access_pkg::BIT_WRITE_STROBE]
    && master_write_enable // R8
    && !flash_selfprog_enable // R13
    && !write_busy;

  assign read_go = ctrl_wr
    && io_req.wdata[eeprom_access_pkg::BIT_READ_STROBE]
    && !write_busy; // R12

  eeprom_write_timer #(
    .WRITE_RC_CYCLES (WRITE_RC_CYCLES)
  ) u_write_timer (
    .core_clk   (core_clk),
    .por_rst    (por_rst),
    .rc_clk_pin (rc_clk_pin),
    .start      (write_go),
    .busy       (write_busy)
  );

  // address carries no reset: its value is undefined until loaded
  always_ff @(posedge core_clk) begin // R3
    if (io_req.wr && !write_busy) begin // R12
      if (hit(io_req.addr, eeprom_access_pkg::OFS_ADDRESS_LOW)) begin
        address_low <= io_req.wdata;
      end
      if (hit(io_req.addr, eeprom_access_pkg::OFS_ADDRESS_HIGH)) begin
        // upper five bits are not stored
        address_high <=
          io_req.wdata[eeprom_access_pkg::ADDR_HIGH_W-1:0]; // R20
      end
    end
  end

  // a read strobe wins over a plain data write in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      eeprom_data_byte <= eeprom_access_pkg::RESET_DATA_BYTE;
    end else if (read_go) begin
      eeprom_data_byte <= array_rdata; // R4 R11
    end else if (io_req.wr
                 && hit(io_req.addr, eeprom_access_pkg::OFS_DATA_BYTE)) begin
      eeprom_data_byte <= io_req.wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ready_interrupt_enable <= 1'b0;
    end else if (ctrl_wr) begin
      ready_interrupt_enable <=
        io_req.wdata[eeprom_access_pkg::BIT_READY_INTERRUPT_ENABLE];
    end
  end

  // the window counts from the write that sets the bit, so setting the
  // strobe in that same write starts nothing unless an earlier write left the window open
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      master_write_enable <= 1'b0;
      mwe_count           <= eeprom_access_pkg::RESET_MWE_COUNT;
    end else if (ctrl_wr
                 && io_req.wdata[eeprom_access_pkg::BIT_MASTER_WRITE_ENABLE])
    begin
      master_write_enable <= 1'b1;
      mwe_count           <= eeprom_access_pkg::MWE_WINDOW_CYCLES;
    end else if (ctrl_wr) begin
      master_write_enable <= 1'b0;
      mwe_count           <= eeprom_access_pkg::RESET_MWE_COUNT;
    end else if (mwe_count != 3'h0) begin
      mwe_count <= mwe_count - 3'h1;
      if (mwe_count == 3'h1) begin
        master_write_enable <= 1'b0; // R7
      end
    end
  end

  // latched at start so later register writes cannot disturb the cell
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      array_req.start <= 1'b0;
      array_req.addr  <= '0;
      array_req.wdata <= 8'h00;
    end else begin
      array_req.start <= write_go;
      if (write_go) begin
        array_req.addr  <= eeprom_address; // R4
        array_req.wdata <= eeprom_data_byte;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      array_read_addr <= '0;
    end else begin
      array_read_addr <= eeprom_address;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stall_left <= eeprom_access_pkg::RESET_STALL;
      cpu_stall  <= 1'b0;
    end else if (write_go) begin
      stall_left <= eeprom_access_pkg::WRITE_STALL_CYCLES; // R10
      cpu_stall  <= 1'b1;
    end else if (read_go) begin
      stall_left <= eeprom_access_pkg::READ_STALL_CYCLES; // R11
      cpu_stall  <= 1'b1;
    end else begin
      if (stall_left != 3'h0) begin
        stall_left <= stall_left - 3'h1;
      end
      cpu_stall <= (stall_left > 3'h1);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ready_irq <= 1'b0;
    end else begin
      ready_irq <= ready_interrupt_enable && global_int_enable
                   && !write_busy && !write_go; // R6
    end
  end

  // a running write must keep its oscillator alive even in power-down
  always_ff @(posedge core_clk or posedge por_rst) begin
    if (por_rst) begin
      rc_osc_keep_on <= 1'b0;
    end else begin
      rc_osc_keep_on <= write_busy || write_go; // R17
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      io_rdata <= eeprom_access_pkg::RESET_RDATA;
    end else if (io_req.rd) begin
      if (hit(io_req.addr, eeprom_access_pkg::OFS_ADDRESS_LOW)) begin
        io_rdata <= address_low;
      end else if (hit(io_req.addr,
                       eeprom_access_pkg::OFS_ADDRESS_HIGH)) begin
        io_rdata <= {5'h00, address_high}; // R1
      end else if (hit(io_req.addr, eeprom_access_pkg::OFS_DATA_BYTE)) begin
        io_rdata <= eeprom_data_byte;
      end else if (hit(io_req.addr, eeprom_access_pkg::OFS_CONTROL)) begin
        io_rdata <= control_view(ready_interrupt_enable,
                                 master_write_enable,
                                 write_busy); // R9
      end else begin
        io_rdata <= 8'h00;
      end
    end
  end

endmodule

// ### sim/eeprom_access_checker.sv
/*
  Port-level properties of the data EEPROM access controller.
  Assumes one core_clk domain with rst as its async reset.
*/
`timescale 1ns/1ns
module eeprom_access_checker #(
  parameter logic [14:0] WRITE_RC_CYCLES = 15'h0008
) (
  input wire logic                             core_clk,
  input wire logic                             rst,
  input wire logic                             por_rst,
  input wire eeprom_access_pkg::io_req_t       io_req,
  input wire logic [7:0]                       io_rdata,
  input wire logic                             global_int_enable,
  input wire logic                             flash_selfprog_enable,
  input wire logic                             rc_clk_pin,
  input wire logic [7:0]                       array_rdata,
  input wire logic [eeprom_access_pkg::ADDR_W-1:0] array_read_addr,
  input wire eeprom_access_pkg::array_req_t    array_req,
  input wire logic                             cpu_stall,
  input wire logic                             ready_irq,
  input wire logic                             rc_osc_keep_on
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  start_pulse_a: assert property (array_req.start |=> !array_req.start)
    else $error("write start longer than one cycle");
  start_cause_a: assert property (array_req.start |->
    $past(io_req.wr) &&
    $past(io_req.wdata[eeprom_access_pkg::BIT_WRITE_STROBE]) &&
    $past(io_req.addr) == eeprom_access_pkg::OFS_CONTROL)
    else $error("write start without a strobe write");
  flash_block_a: assert property (array_req.start |->
    !$past(flash_selfprog_enable))
    else $error("write started during flash programming");
  write_stall_a: assert property (array_req.start |->
    cpu_stall[*2] ##1 !cpu_stall)
    else $error("write stall is not two cycles");
  stall_bound_a: assert property (cpu_stall[*4] |=> !cpu_stall)
    else $error("stall longer than four cycles");
  // an idle oscillator hold one edge later means no write was running
  read_stall_a: assert property ($past(io_req.wr) && !$past(rst) &&
    $past(io_req.addr) == eeprom_access_pkg::OFS_CONTROL &&
    $past(io_req.wdata[eeprom_access_pkg::BIT_READ_STROBE]) &&
    !$past(io_req.wdata[eeprom_access_pkg::BIT_WRITE_STROBE]) &&
    !rc_osc_keep_on |-> cpu_stall[*4] ##1 !cpu_stall)
    else $error("read stall is not four cycles");
  irq_drop_a: assert property (array_req.start |-> !ready_irq)
    else $error("ready request during write start");
  irq_gate_a: assert property (ready_irq |-> $past(global_int_enable))
    else $error("ready request with interrupts off");
  keep_on_a: assert property (array_req.start |->
    ##[1:2] rc_osc_keep_on)
    else $error("oscillator not held during write");
  addr_frozen_a: assert property (rc_osc_keep_on &&
    $past(rc_osc_keep_on) && !$past(rst) && !$past(rst, 2)
    |-> $stable(array_read_addr))
    else $error("address changed during write");
  high_reserved_a: assert property ($past(io_req.rd) &&
    $past(io_req.addr) == eeprom_access_pkg::OFS_ADDRESS_HIGH
    |-> io_rdata[7:3] == 5'h00)
    else $error("reserved address bits read nonzero");
  ctrl_reserved_a: assert property ($past(io_req.rd) &&
    $past(io_req.addr) == eeprom_access_pkg::OFS_CONTROL
    |-> io_rdata[7:4] == 4'h0)
    else $error("reserved control bits read nonzero");
  cover property (array_req.start);
  cover property (ready_irq);
  cover property (cpu_stall[*4]);
endmodule
bind eeprom_access_controller eeprom_access_checker #(
  .WRITE_RC_CYCLES(WRITE_RC_CYCLES)) i_chk (.core_clk(core_clk), .rst(rst),
  .por_rst(por_rst), .io_req(io_req), .io_rdata(io_rdata),
  .global_int_enable(global_int_enable), .rc_clk_pin(rc_clk_pin),
  .flash_selfprog_enable(flash_selfprog_enable), .array_rdata(array_rdata),
  .array_read_addr(array_read_addr), .array_req(array_req),
  .cpu_stall(cpu_stall), .ready_irq(ready_irq),
  .rc_osc_keep_on(rc_osc_keep_on));

// ### sim/tb.sv
/*
  Directed testbench for the data EEPROM access controller.
  Assumes the package and the checker are compiled before it.
*/
`timescale 1ns/1ns
module tb;
  localparam logic [5:0] LOW  = eeprom_access_pkg::OFS_ADDRESS_LOW;
  localparam logic [5:0] HIGH = eeprom_access_pkg::OFS_ADDRESS_HIGH;
  localparam logic [5:0] DATA = eeprom_access_pkg::OFS_DATA_BYTE;
  localparam logic [5:0] CTRL = eeprom_access_pkg::OFS_CONTROL;
  logic                        core_clk = 1'b0;
  logic                        rst = 1'b1;
  logic                        por_rst = 1'b1;
  logic                        gie = 1'b0;
  logic                        flash = 1'b0;
  logic                        rc_clk = 1'b0;
  eeprom_access_pkg::io_req_t  io_req = '0;
  eeprom_access_pkg::array_req_t array_req;
  logic [7:0]                  io_rdata;
  logic [7:0]                  array_rdata;
  logic [10:0]                 array_read_addr;
  logic                        cpu_stall;
  logic                        ready_irq;
  logic                        keep_on;
  logic [7:0]                  mem [0:2047];
  logic [7:0]                  d;
  logic [7:0]                  stall_cnt = 8'h00;
  logic [7:0]                  start_cnt = 8'h00;
  int                          fail_count = 0;
  int                          check_count = 0;
  eeprom_access_controller #(.WRITE_RC_CYCLES(15'h0008)) i_dut (
    .core_clk(core_clk), .rst(rst), .por_rst(por_rst), .io_req(io_req),
    .io_rdata(io_rdata), .global_int_enable(gie),
    .flash_selfprog_enable(flash), .rc_clk_pin(rc_clk),
    .array_rdata(array_rdata), .array_read_addr(array_read_addr),
    .array_req(array_req), .cpu_stall(cpu_stall), .ready_irq(ready_irq),
    .rc_osc_keep_on(keep_on));
  always #10 core_clk = ~core_clk;
  // oscillator period unrelated to the core clock
  always #13 rc_clk = ~rc_clk;
  assign array_rdata = mem[array_read_addr];
  always @(posedge core_clk) begin
    if (cpu_stall === 1'b1) stall_cnt++;
    if (array_req.start === 1'b1) begin
      start_cnt++;
      mem[array_req.addr] = array_req.wdata;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic io_wr(input logic [5:0] a, input logic [7:0] v);
    @(negedge core_clk);
    io_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge core_clk);
    io_req = '0;
  endtask
  task automatic io_rd(input logic [5:0] a, output logic [7:0] v);
    @(negedge core_clk);
    io_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge core_clk);
    io_req = '0;
    v = io_rdata;
  endtask
  // gap plus one gives the idle cycles between the enable write and the strobe write
  task automatic arm(input int gap, input logic [7:0] base);
    io_wr(CTRL, base | 8'h04);
    repeat (gap) @(negedge core_clk);
    io_wr(CTRL, base | 8'h02);
  endtask
  task automatic wait_done();
    for (int i = 0; i < 40; i++) begin
      io_rd(CTRL, d);
      if (d[1] === 1'b0) return;
    end
    chk(d, 8'h00);
  endtask
  task automatic t_regs();
    io_rd(CTRL, d);
    chk(d, 8'h00);
    io_wr(CTRL, 8'hf0);
    io_rd(CTRL, d);
    chk(d, 8'h00);
    io_wr(HIGH, 8'hff);
    io_wr(LOW, 8'h5a);
    io_rd(HIGH, d);
    chk(d, 8'h07);
    io_rd(LOW, d);
    chk(d, 8'h5a);
    io_rd(6'h30, d);
    chk(d, 8'h00);
  endtask
  task automatic t_write();
    time t0;
    io_wr(DATA, 8'h3c);
    stall_cnt = 8'h00;
    // interrupts stay off through the whole write sequence here
    arm(2, 8'h00);
    t0 = $time;
    repeat (3) @(negedge core_clk);
    chk(start_cnt, 8'h01);
    chk(stall_cnt, 8'h02);
    chk({7'h00, keep_on}, 8'h01);
    io_rd(CTRL, d);
    chk(d & 8'h02, 8'h02);
    io_wr(LOW, 8'h00);
    io_wr(DATA, 8'h11);
    io_wr(CTRL, 8'h01);
    io_rd(DATA, d);
    chk(d, 8'h11);
    wait_done();
    // eight rising oscillator edges after the start take seven periods
    chk({7'h00, ($time - t0) >= 182}, 8'h01);
    io_rd(LOW, d);
    chk(d, 8'h5a);
    chk(mem[11'h75a], 8'h3c);
    stall_cnt = 8'h00;
    io_wr(CTRL, 8'h01);
    io_rd(DATA, d);
    chk(d, 8'h3c);
    repeat (3) @(negedge core_clk);
    chk(stall_cnt, 8'h04);
  endtask
  task automatic t_refuse();
    start_cnt = 8'h00;
    io_wr(CTRL, 8'h04);
    io_rd(CTRL, d);
    chk(d, 8'h04);
    repeat (3) @(negedge core_clk);
    io_rd(CTRL, d);
    chk(d, 8'h00);
    io_wr(CTRL, 8'h02);
    arm(3, 8'h00);
    flash = 1'b1;
    arm(0, 8'h00);
    flash = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(start_cnt, 8'h00);
  endtask
  task automatic t_irq();
    gie = 1'b1;
    io_wr(CTRL, 8'h08);
    @(negedge core_clk);
    chk({7'h00, ready_irq}, 8'h01);
    arm(1, 8'h08);
    @(negedge core_clk);
    chk({7'h00, ready_irq}, 8'h00);
    rst = 1'b1;
    @(negedge core_clk);
    rst = 1'b0;
    io_rd(CTRL, d);
    chk(d & 8'h02, 8'h02);
    chk({7'h00, keep_on}, 8'h01);
    wait_done();
    io_wr(CTRL, 8'h08);
    @(negedge core_clk);
    chk({7'h00, ready_irq}, 8'h01);
    gie = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({7'h00, ready_irq}, 8'h00);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    por_rst = 1'b0;
    t_regs();
    t_write();
    t_refuse();
    t_irq();
    conclude();
  end
endmodule
